/* dv/rtc_indirect_access_chk.sv */
`timescale 1ns/1ps
module rtc_indirect_access_chk
    import rtc_access_pkg::*;
#(parameter int MISSING_TIMEOUT = 20) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       lf_clk_i,
    input wire logic       osc_enable_o,
    input wire logic       alarm_event_o,
    input wire logic       osc_fail_o,
    input wire logic       short_strobe_o
);
    localparam int FLAG_MAX = 20;
    logic        lf_q;
    logic [15:0] stuck_q;
    // Stuck-level run length, cleared while the oscillator is off
    always_ff @(posedge clk_i) begin
        lf_q    <= lf_clk_i;
        stuck_q <= (!osc_enable_o || lf_clk_i != lf_q) ? 16'h0000 : stuck_q + 16'h0001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    rdata_idle_a: assert property (!(sfr_rd_i && sfr_addr_i inside {8'hAC, 8'hAD})
        |=> sfr_rdata_o == 8'h00) else $error("read data not idle");
    short_read_a: assert property (sfr_rd_i && sfr_addr_i == ADDR_SELECT_SFR
        |=> sfr_rdata_o[SEL_SHORT_BIT] == $past(short_strobe_o)) else $error("short readback");
    osc_cause_a: assert property ($changed(osc_enable_o)
        |-> $past(sfr_wr_i) && $past(sfr_addr_i) == DATA_PORT_SFR) else $error("osc moved");
    short_cause_a: assert property ($changed(short_strobe_o)
        |-> $past(sfr_wr_i) && $past(sfr_addr_i) == ADDR_SELECT_SFR) else $error("short moved");
    fail_clear_a: assert property ($fell(osc_fail_o) |-> $past(sfr_wr_i)
        && ($past(sfr_wdata_i) & 8'h20) == 8'h00) else $error("fail flag dropped");
    fail_time_a: assert property ($rose(osc_fail_o)
        |-> stuck_q >= 16'(MISSING_TIMEOUT - 2)) else $error("fail flag early");
    flag_drop_a: assert property ($rose(alarm_event_o) |-> ##[1:FLAG_MAX] !alarm_event_o)
        else $error("alarm flag stuck");
    flag_edge_a: assert property ($rose(alarm_event_o) |-> osc_enable_o && $past(lf_clk_i))
        else $error("alarm off slow edge");
    alarm_c: cover property ($rose(alarm_event_o));
    fail_c: cover property ($rose(osc_fail_o));
    short_c: cover property ($rose(short_strobe_o));
endmodule : rtc_indirect_access_chk

bind rtc_indirect_access rtc_indirect_access_chk #(.MISSING_TIMEOUT(MISSING_TIMEOUT)) chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .lf_clk_i(lf_clk_i), .osc_enable_o(osc_enable_o), .alarm_event_o(alarm_event_o),
    .osc_fail_o(osc_fail_o), .short_strobe_o(short_strobe_o));

/* dv/sfr_host_model.sv */
`timescale 1ns/1ps
module sfr_host_model (
    input  wire logic       clk_i,
    output logic      [7:0] sfr_addr_o,
    output logic            sfr_wr_o,
    output logic            sfr_rd_o,
    output logic      [7:0] sfr_wdata_o,
    input  wire logic [7:0] sfr_rdata_i
);
    import rtc_access_pkg::*;
    int miss = 0;
    initial begin
        sfr_addr_o  = 8'h00;
        sfr_wr_o    = 1'b0;
        sfr_rd_o    = 1'b0;
        sfr_wdata_o = 8'h00;
    end
    // Released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_o  <= a;
        sfr_wdata_o <= (a == ADDR_SELECT_SFR) ? (d & 8'hDF) : d;
        sfr_wr_o    <= 1'b1;
        @(posedge clk_i);
        sfr_wr_o    <= 1'b0;
        sfr_addr_o  <= ~a;
        sfr_wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_o <= a;
        sfr_rd_o   <= 1'b1;
        @(posedge clk_i);
        sfr_rd_o   <= 1'b0;
        sfr_addr_o <= ~a;
        #1 d = sfr_rdata_i;
    endtask : rd
    // Gives up after 16 polls and counts the miss
    task automatic idle();
        logic [7:0] v;
        v = 8'hFF;
        for (int i = 0; i < 16 && v[SEL_BUSY_BIT]; i++) rd(ADDR_SELECT_SFR, v);
        if (v[SEL_BUSY_BIT]) miss++;
    endtask : idle
    task automatic iwr(input logic [3:0] a, input logic [7:0] d);
        idle();
        wr(ADDR_SELECT_SFR, {4'h0, a});
        wr(DATA_PORT_SFR, d);
    endtask : iwr
    task automatic ird(input logic [3:0] a, output logic [7:0] d);
        idle();
        wr(ADDR_SELECT_SFR, {4'h8, a});
        idle();
        rd(DATA_PORT_SFR, d);
    endtask : ird
endmodule : sfr_host_model

/* dv/tb_rtc_indirect_access.sv */
`timescale 1ns/1ps
module tb_rtc_indirect_access;
    import rtc_access_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, lf_clk_i = 1'b0, lf_run = 1'b1, found;
    logic sfr_wr_i, sfr_rd_i, osc_enable_o, alarm_event_o, osc_fail_o, short_strobe_o;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, v;
    logic [31:0] base, t;
    int lf_div = 0, fail_count = 0, n_checks = 0;
    always #5 clk_i = ~clk_i;
    // Slow clock of 16 core cycles, stalls while lf_run is low
    always @(posedge clk_i) begin
        lf_div <= (lf_div + 1) % 8;
        if (lf_div == 7 && lf_run) lf_clk_i <= ~lf_clk_i;
    end
    rtc_indirect_access #(.MISSING_TIMEOUT(20)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .lf_clk_i(lf_clk_i),
        .osc_enable_o(osc_enable_o), .alarm_event_o(alarm_event_o),
        .osc_fail_o(osc_fail_o), .short_strobe_o(short_strobe_o));
    sfr_host_model m_u (.clk_i(clk_i), .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i),
        .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i), .sfr_rdata_i(sfr_rdata_o));
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic settle(input int b);
        int i;
        for (i = 0; i < 8; i++) begin
            m_u.ird(IND_CONTROL, v);
            if (!v[b]) break;
        end
        chk(i < 8, 1'b1);
        if (i == 8) close_out();
    endtask : settle
    task automatic snap(output logic [31:0] w);
        m_u.iwr(IND_CONTROL, 8'h81);
        settle(CTL_SNAP_BIT);
        for (int i = 0; i < 4; i++) begin
            m_u.ird(4'(i), v);
            w[8*i+:8] = v;
        end
    endtask : snap
    task automatic put4(input logic [3:0] a, input logic [31:0] w);
        m_u.iwr(a, w[7:0]);
        for (int i = 1; i < 4; i++) m_u.wr(DATA_PORT_SFR, w[8*i+:8]);
    endtask : put4
    initial begin
        void'($urandom(32'h1A89));
        base = $urandom();
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        m_u.rd(8'h55, v);
        chk(v, 8'h00);
        put4(IND_SNAP_FIRST, base);
        m_u.rd(ADDR_SELECT_SFR, v);
        chk(v, 8'h04);
        m_u.wr(ADDR_SELECT_SFR, 8'hC0);
        for (int i = 0; i < 4; i++) begin
            m_u.idle();
            m_u.rd(DATA_PORT_SFR, v);
            chk(v, base[8*i+:8]);
        end
        m_u.idle();
        m_u.rd(ADDR_SELECT_SFR, v);
        chk({v, short_strobe_o}, 9'h088);
        m_u.wr(ADDR_SELECT_SFR, 8'h10);
        m_u.rd(ADDR_SELECT_SFR, v);
        chk({v, short_strobe_o}, 9'h021);
        m_u.iwr(IND_CONTROL, 8'h82);
        settle(CTL_LOAD_BIT);
        snap(t);
        chk({osc_enable_o, t}, {1'b1, base});
        m_u.iwr(IND_CONTROL, 8'h90);
        repeat (160) @(posedge clk_i);
        snap(t);
        chk((t - base) inside {[32'd9:32'd12]}, 1'b1);
        put4(IND_MATCH_FIRST, t + 32'd3);
        m_u.iwr(IND_CONTROL, 8'h9C);
        found = 1'b0;
        for (int i = 0; i < 300 && !found; i++) @(negedge clk_i) found = alarm_event_o;
        chk(found, 1'b1);
        if (!found) close_out();
        repeat (64) @(posedge clk_i);
        snap(t);
        chk(t < 32'd8, 1'b1);
        m_u.iwr(IND_CONTROL, 8'h84);
        m_u.ird(IND_CONTROL, v);
        chk(v, 8'h80);
        lf_run <= 1'b0;
        m_u.iwr(IND_CONTROL, 8'hC0);
        repeat (60) @(posedge clk_i);
        chk(osc_fail_o, 1'b1);
        lf_run <= 1'b1;
        repeat (40) @(posedge clk_i);
        m_u.iwr(IND_CONTROL, 8'hC0);
        m_u.rd(8'h55, v);
        chk(osc_fail_o, 1'b0);
        m_u.iwr(IND_CONTROL, 8'h00);
        m_u.rd(8'h55, v);
        chk(osc_enable_o, 1'b0);
        chk(m_u.miss, 0);
        close_out();
    end
endmodule : tb_rtc_indirect_access

/* hdl/missing_clock_detect.sv */
`timescale 1ns/1ps
module missing_clock_detect #(
    parameter int TIMEOUT_CYCLES = rtc_access_pkg::MISSING_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic enable_i,
    input  wire logic lf_level_i,
    output logic      timeout_o
);
    import rtc_access_pkg::*;

    typedef struct packed {
        logic        last_level;
        logic [31:0] count;
        logic        fired;
        logic        timeout;
    } mcd_state_t;

    mcd_state_t s_q;
    mcd_state_t s_d;

    // One-shot: fires once per stall, rearmed by the next level change
    always_comb begin
        s_d            = s_q;
        s_d.last_level = lf_level_i;
        s_d.timeout    = 1'b0;
        if (!enable_i || (lf_level_i != s_q.last_level)) begin
            s_d.count = RESET_WORD;
            s_d.fired = 1'b0;
        end else if (s_q.count >= 32'(TIMEOUT_CYCLES)) begin
            s_d.timeout = !s_q.fired;
            s_d.fired   = 1'b1;
        end else begin
            s_d.count = s_q.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign timeout_o = s_q.timeout;
endmodule : missing_clock_detect

/* hdl/rtc_access_pkg.sv */
package rtc_access_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_SELECT_SFR  = 8'hAC;
    localparam logic [7:0] DATA_PORT_SFR    = 8'hAD;

    // Indirect (internal) register addresses
    localparam logic [3:0] IND_SNAP_FIRST   = 4'h0;
    localparam logic [3:0] IND_SNAP_LAST    = 4'h3;
    localparam logic [3:0] IND_CONTROL      = 4'h4;
    localparam logic [3:0] IND_MATCH_FIRST  = 4'h8;
    localparam logic [3:0] IND_MATCH_LAST   = 4'hB;

    // indirect_address_select fields
    localparam int SEL_BUSY_BIT   = 7;
    localparam int SEL_AUTO_READ_ENABLE_BIT = 6;
    localparam int SEL_SHORT_BIT  = 4;
    localparam int SEL_ADDR_MSB   = 3;

    // clock_control fields
    localparam int CTL_OSC_EN_BIT = 7;
    localparam int CTL_MCD_EN_BIT = 6;
    localparam int CTL_FAIL_BIT   = 5;
    localparam int CTL_RUN_BIT    = 4;
    localparam int CTL_AEN_BIT    = 3;
    localparam int CTL_ALARM_BIT  = 2;
    localparam int CTL_LOAD_BIT   = 1;
    localparam int CTL_SNAP_BIT   = 0;

    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Indirect read latency in core cycles, normal and short strobe
    localparam logic [1:0] READ_LAT_LONG  = 2'h2;
    localparam logic [1:0] READ_LAT_SHORT = 2'h1;

    // Missing clock timeout
    localparam int CLK_PERIOD_NS    = 10;
    localparam int MISSING_TIME_NS  = 100000;
    localparam int MISSING_CYCLES   = MISSING_TIME_NS / CLK_PERIOD_NS;
endpackage : rtc_access_pkg

/* hdl/rtc_indirect_access.sv */
`timescale 1ns/1ps
module rtc_indirect_access #(
    parameter int MISSING_TIMEOUT = rtc_access_pkg::MISSING_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       lf_clk_i,
    output logic            osc_enable_o,
    output logic            alarm_event_o,
    output logic            osc_fail_o,
    output logic            short_strobe_o
);
    import rtc_access_pkg::*;

    typedef struct packed {
        logic [7:0]  rdata;
        logic        busy;
        logic [1:0]  wait_cnt;
        logic        auto_read_enable;
        logic        short_strobe;
        logic [3:0]  addr;
        logic [7:0]  data_port;
        logic        oscillator_enable;
        logic        missing_clock_detect_enable;
        logic        oscillator_failure_flag;
        logic        timer_run;
        logic        alarm_enable;
        logic        autoreset_enable;
        logic        alarm_flag;
        logic        autoreset_due;
        logic        timer_load_start;
        logic        timer_snapshot_start;
        logic        lf_prev;
        logic [31:0] timer;
        logic [31:0] snapshot_bytes;
        logic [31:0] match_value_bytes;
    } rtc_state_t;

    rtc_state_t s_q;
    rtc_state_t s_d;
    logic       mcd_timeout;

    function automatic logic in_range(input logic [3:0] a, input logic [3:0] lo,
                                      input logic [3:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] idx);
        byte_of = w[8*idx +: 8];
    endfunction : byte_of

    function automatic logic autoinc(input logic [3:0] a);
        autoinc = in_range(a, IND_SNAP_FIRST, IND_SNAP_LAST)
               || in_range(a, IND_MATCH_FIRST, IND_MATCH_LAST);
    endfunction : autoinc

    function automatic logic [7:0] control_byte(input rtc_state_t s);
        control_byte = RESET_BYTE;
        control_byte[CTL_OSC_EN_BIT] = s.oscillator_enable;
        control_byte[CTL_MCD_EN_BIT] = s.missing_clock_detect_enable;
        control_byte[CTL_FAIL_BIT]   = s.oscillator_failure_flag;
        control_byte[CTL_RUN_BIT]    = s.timer_run;
        control_byte[CTL_AEN_BIT]    = s.alarm_enable;
        control_byte[CTL_ALARM_BIT]  = s.alarm_flag;
        control_byte[CTL_LOAD_BIT]   = s.timer_load_start;
        control_byte[CTL_SNAP_BIT]   = s.timer_snapshot_start;
    endfunction : control_byte

    missing_clock_detect #(
        .TIMEOUT_CYCLES (MISSING_TIMEOUT)
    ) u_mcd (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (s_q.missing_clock_detect_enable && s_q.oscillator_enable),
        .lf_level_i (lf_clk_i),
        .timeout_o  (mcd_timeout)
    );

    always_comb begin
        logic       lf_edge;
        logic       start_read;
        logic [7:0] sel_byte;
        logic [7:0] ctl_w;
        lf_edge    = 1'b0;
        start_read = 1'b0;
        sel_byte   = RESET_BYTE;
        ctl_w      = sfr_wdata_i;
        s_d        = s_q;
        s_d.rdata  = RESET_BYTE;
        s_d.lf_prev = lf_clk_i;
        lf_edge    = lf_clk_i && !s_q.lf_prev && s_q.oscillator_enable;

        // Selected internal register contents
        if (in_range(s_q.addr, IND_SNAP_FIRST, IND_SNAP_LAST)) begin
            sel_byte = byte_of(s_q.snapshot_bytes, s_q.addr[1:0]);
        end else if (in_range(s_q.addr, IND_MATCH_FIRST, IND_MATCH_LAST)) begin
            sel_byte = byte_of(s_q.match_value_bytes, s_q.addr[1:0]);
        end else if (s_q.addr == IND_CONTROL) begin
            sel_byte = control_byte(s_q);
        end

        // Register reads
        if (sfr_rd_i) begin
            if (sfr_addr_i == ADDR_SELECT_SFR) begin
                s_d.rdata = {s_q.busy, s_q.auto_read_enable, 1'b0,
                             s_q.short_strobe, s_q.addr};
            end else if (sfr_addr_i == DATA_PORT_SFR) begin
                s_d.rdata = s_q.data_port;
                if (s_q.auto_read_enable && !s_q.busy) begin
                    start_read = 1'b1;
                end
            end
        end

        // Register writes
        if (sfr_wr_i && sfr_addr_i == ADDR_SELECT_SFR && !s_q.busy) begin
            s_d.auto_read_enable = sfr_wdata_i[SEL_AUTO_READ_ENABLE_BIT];
            s_d.short_strobe     = sfr_wdata_i[SEL_SHORT_BIT];
            s_d.addr             = sfr_wdata_i[SEL_ADDR_MSB:0];
            start_read           = sfr_wdata_i[SEL_BUSY_BIT];
        end

        if (sfr_wr_i && sfr_addr_i == DATA_PORT_SFR && !s_q.busy) begin
            s_d.data_port = sfr_wdata_i;
            if (in_range(s_q.addr, IND_SNAP_FIRST, IND_SNAP_LAST)) begin
                s_d.snapshot_bytes[8*s_q.addr[1:0] +: 8] = sfr_wdata_i;
            end else if (in_range(s_q.addr, IND_MATCH_FIRST, IND_MATCH_LAST)) begin
                s_d.match_value_bytes[8*s_q.addr[1:0] +: 8] = sfr_wdata_i;
            end else if (s_q.addr == IND_CONTROL) begin
                s_d.oscillator_enable           = ctl_w[CTL_OSC_EN_BIT];
                s_d.missing_clock_detect_enable = ctl_w[CTL_MCD_EN_BIT];
                if (!ctl_w[CTL_FAIL_BIT]) begin
                    s_d.oscillator_failure_flag = 1'b0;
                end
                s_d.timer_run        = ctl_w[CTL_RUN_BIT];
                s_d.alarm_enable     = ctl_w[CTL_AEN_BIT];
                if (ctl_w[CTL_AEN_BIT] != s_q.alarm_enable) begin
                    s_d.alarm_flag = 1'b0;
                end
                s_d.autoreset_enable = ctl_w[CTL_ALARM_BIT];
                if (ctl_w[CTL_LOAD_BIT]) begin
                    s_d.timer_load_start = 1'b1;
                end
                if (ctl_w[CTL_SNAP_BIT]) begin
                    s_d.timer_snapshot_start = 1'b1;
                end
            end
            if (autoinc(s_q.addr)) begin
                s_d.addr = s_q.addr + 4'h1;
            end
        end

        // Indirect read sequencing
        if (start_read) begin
            s_d.busy     = 1'b1;
            s_d.wait_cnt = s_d.short_strobe ? READ_LAT_SHORT : READ_LAT_LONG;
        end else if (s_q.busy) begin
            if (s_q.wait_cnt == 2'h1) begin
                s_d.busy      = 1'b0;
                s_d.data_port = sel_byte;
                if (autoinc(s_q.addr)) begin
                    s_d.addr = s_q.addr + 4'h1;
                end
            end
            s_d.wait_cnt = s_q.wait_cnt - 2'h1;
        end

        // Slow clock domain work, paced by the oscillator edge
        if (lf_edge) begin
            s_d.alarm_flag    = 1'b0;
            s_d.autoreset_due = 1'b0;
            if (s_q.timer_load_start) begin
                s_d.timer            = s_q.snapshot_bytes;
                s_d.timer_load_start = 1'b0;
            end else if (s_q.autoreset_due) begin
                s_d.timer = RESET_WORD;
            end else if (s_q.timer_run) begin
                s_d.timer = s_q.timer + 32'h0000_0001;
            end
            if (s_q.timer_snapshot_start) begin
                s_d.snapshot_bytes       = s_q.timer;
                s_d.timer_snapshot_start = 1'b0;
            end
            // A disabling write in the same cycle wins over a new match
            if (s_q.alarm_enable && s_d.alarm_enable && s_q.timer == s_q.match_value_bytes
                && !s_q.alarm_flag) begin
                s_d.alarm_flag    = 1'b1;
                s_d.autoreset_due = s_q.autoreset_enable;
            end
        end

        // Set wins over a simultaneous software clear
        if (mcd_timeout) begin
            s_d.oscillator_failure_flag = 1'b1;
        end
    end

    // Failure flag gets zero at reset for determinism only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata_o    = s_q.rdata;
    assign osc_enable_o   = s_q.oscillator_enable;
    assign alarm_event_o  = s_q.alarm_flag;
    assign osc_fail_o     = s_q.oscillator_failure_flag;
    assign short_strobe_o = s_q.short_strobe;
endmodule : rtc_indirect_access
